//--- logic/ccg_ctrl.sv
// Operation
// - Spread settings of any amount are stored unchanged, never clamped.
// - Strap high and flag clear: load config picked by select pins, serial off.
// - Strap low: serial on; flag set loads defaults, else config zero.
// - In pin mode, follow select pins only after the first 10 ms.
// - After a select change, hold off 1 ms while the new config loads.
// - Active reference is primary bit XOR select pin; zero means crystal.
// - Switchover mode 0x: pin switches references, without output glitches.
// - Save bit copies registers to OTP; restore bit reloads them.
// - OTP command is address plus code byte; runs only after STOP.
// - No acknowledge while an OTP save or restore runs.
// - Restore OTP at power-up; accept programming once address is acked.
// - Slave address 0xD4 by default, 0xD0 with address-select bit set.
// - Enable mode: polarity bit zero makes the pin active low, one active high.
// - Function bit high: pin is PLL shutdown; low: output enable.
// - Global shutdown powers down and forces outputs to fixed levels.
// - State bit zero tri-states the output unless global shutdown.
// - Enable mode: enable bit zero keeps active, else pin may force level.
// - Shutdown mode, pin low: force level only if enable and polarity set.
// - Block writes are staged and committed together at STOP.
`timescale 1ns/1ps
`default_nettype none
module ccg_ctrl
    import ccg_pkg::*;
#(
    parameter int START_CYC = SEL_START_CYC,
    parameter int SETTLE_CYC = SEL_SETTLE_CYC,
    parameter int OUTS = OUT_COUNT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_access_strap,
    input wire logic config_select_low,
    input wire logic config_select_high,
    input wire logic reference_select_pin,
    input wire logic shutdown_enable_pin,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [BANK_W+IDX_W-1:0] otp_addr,
    output logic [7:0] otp_wdata,
    output logic otp_we,
    input wire logic [7:0] otp_rdata,
    output logic busy,
    output logic serial_access_enabled,
    output logic [BANK_W-1:0] config_active,
    output logic use_external_reference,
    output logic pll_shutdown,
    output logic [OUTS-1:0] clock_output_active,
    output logic [OUTS-1:0] clock_output_tristate
);
    logic [6:0] pin_meta_r, pin_sync_r;
    logic strap_s, reference_select_pin_s, sdoe_s, scl_s, sda_s, scl_d_r, sda_d_r;
    logic [1:0] sel_s;
    logic scl_rise, scl_fall, start_ev, stop_ev;
    logic [7:0] regs_r [REG_COUNT];
    logic otp_serial_default_flag, addr_select_bit, primary_source_bit;
    logic [1:0] switchover_mode_field;
    logic pin_polarity_bit, pin_function_bit;
    logic [OUTS-1:0] output_state_bit, output_enable_bit, act_v, tri_v;
    ccg_state_type st_r;
    logic [IDX_W:0] cnt_r;
    logic [BANK_W-1:0] bank_r;
    logic boot_r, strap_r, pin_mode_r, serial_en_r;
    logic ld_v1_r, ld_v2_r;
    logic [IDX_W-1:0] ld_idx1_r, ld_idx2_r;
    logic [31:0] start_cnt_r, settle_cnt_r;
    logic start_ok, settle_done, reload_sel, clear_defaults, commit, save_req, restore_req, gsd;
    ccg_phase_type ph_r;
    logic [3:0] bitcnt_r, nbytes_r;
    logic [7:0] shift_r, rd_byte_r, reg_ptr_r, rd_data;
    logic [7:0] stage_r [STAGE_DEPTH];
    logic [8:0] wr_idx [STAGE_DEPTH];
    logic wr_pend_r, sda_low_r;
    logic [6:0] my_addr;

    // Pins come from the board, so all pass two flops before use
    always_ff @(posedge clk) begin
        if (rst) begin
            // Bus lines reset to their idle high level so no false edge follows reset
            pin_meta_r <= 7'h03;
            pin_sync_r <= 7'h03;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            pin_meta_r <= {serial_access_strap, config_select_high, config_select_low,
                           reference_select_pin, shutdown_enable_pin, scl_in, sda_in};
            pin_sync_r <= pin_meta_r;
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end
    assign {strap_s, sel_s, reference_select_pin_s, sdoe_s, scl_s, sda_s} = pin_sync_r;
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;

    assign otp_serial_default_flag = regs_r[REG_FLAGS][BIT_SERIAL_DEFAULT];
    assign addr_select_bit = regs_r[REG_FLAGS][BIT_ADDR_SELECT];
    assign primary_source_bit = regs_r[REG_REF][BIT_PRIMARY_SOURCE];
    assign switchover_mode_field = regs_r[REG_REF][BIT_SWITCH_MODE_LO+1:BIT_SWITCH_MODE_LO];
    assign pin_polarity_bit = regs_r[REG_PIN_CTRL][BIT_PIN_POLARITY];
    assign pin_function_bit = regs_r[REG_PIN_CTRL][BIT_PIN_FUNCTION];
    assign busy = st_r != ST_RUN;
    assign commit = stop_ev & wr_pend_r & (st_r == ST_RUN);
    assign clear_defaults = (st_r == ST_PICK) & ~strap_r & otp_serial_default_flag;
    assign start_ok = start_cnt_r == 32'(START_CYC);
    assign settle_done = settle_cnt_r == '0;
    assign reload_sel = (st_r == ST_RUN) & pin_mode_r & start_ok & settle_done
                        & (sel_s != bank_r) & ~save_req & ~restore_req;

    always_comb begin
        save_req = 1'b0;
        restore_req = 1'b0;
        for (int i = 0; i < STAGE_DEPTH; i++) begin
            wr_idx[i] = {1'b0, reg_ptr_r} + 9'(i);
        end
        if (commit) begin
            // A bare code byte followed by STOP is the short OTP command form
            if (nbytes_r == '0) begin
                save_req = reg_ptr_r == CMD_OTP_SAVE;
                restore_req = reg_ptr_r == CMD_OTP_RESTORE;
            end
            for (int i = 0; i < STAGE_DEPTH; i++) begin
                if (4'(i) < nbytes_r && wr_idx[i] == {2'b00, REG_OTP_CTRL}) begin
                    save_req = save_req | stage_r[i][BIT_OTP_SAVE];
                    restore_req = restore_req | stage_r[i][BIT_OTP_RESTORE];
                end
            end
        end
    end

    // Register file: OTP load, defaults and STOP commit are mutually exclusive by state
    always_ff @(posedge clk) begin
        if (rst || clear_defaults) begin
            for (int i = 0; i < REG_COUNT; i++) regs_r[i] <= REG_RESET_VAL;
        end else if (ld_v2_r) begin
            regs_r[ld_idx2_r] <= otp_rdata;
        end else if (commit) begin
            // Any value is taken as written, spread settings included
            for (int i = 0; i < STAGE_DEPTH; i++) begin
                if (4'(i) < nbytes_r && wr_idx[i] < 9'(REG_COUNT))
                    regs_r[wr_idx[i][IDX_W-1:0]] <= stage_r[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            start_cnt_r <= '0;
            settle_cnt_r <= '0;
        end else begin
            if (!start_ok) start_cnt_r <= start_cnt_r + 32'h1;
            if (reload_sel) settle_cnt_r <= 32'(SETTLE_CYC);
            else if (!settle_done) settle_cnt_r <= settle_cnt_r - 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ld_v1_r <= 1'b0;
            ld_v2_r <= 1'b0;
            ld_idx1_r <= '0;
            ld_idx2_r <= '0;
        end else begin
            ld_v1_r <= st_r == ST_LOAD;
            ld_idx1_r <= cnt_r[IDX_W-1:0];
            ld_v2_r <= ld_v1_r;
            ld_idx2_r <= ld_idx1_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= ST_STRAP;
            cnt_r <= '0;
            bank_r <= '0;
            boot_r <= 1'b1;
            strap_r <= 1'b0;
            pin_mode_r <= 1'b0;
            serial_en_r <= 1'b0;
            otp_addr <= '0;
            otp_wdata <= '0;
            otp_we <= 1'b0;
        end else begin
            otp_we <= 1'b0;
            case (st_r)
                ST_STRAP: if (start_cnt_r == STRAP_SAMPLE_CYC) begin
                    strap_r <= strap_s;
                    cnt_r <= '0;
                    st_r <= ST_LOAD;
                end
                ST_LOAD: begin
                    otp_addr <= {bank_r, cnt_r[IDX_W-1:0]};
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r[IDX_W-1:0] == IDX_W'(REG_COUNT - 1)) begin
                        cnt_r <= '0;
                        st_r <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == LOAD_DRAIN_CYC) begin
                        cnt_r <= '0;
                        st_r <= boot_r ? ST_PICK : ST_RUN;
                    end
                end
                ST_PICK: begin
                    boot_r <= 1'b0;
                    pin_mode_r <= strap_r & ~otp_serial_default_flag;
                    serial_en_r <= ~(strap_r & ~otp_serial_default_flag);
                    if (strap_r && !otp_serial_default_flag) begin
                        bank_r <= sel_s;
                        st_r <= ST_LOAD;
                    end else begin
                        st_r <= ST_RUN;
                    end
                end
                ST_SAVE: begin
                    otp_we <= 1'b1;
                    otp_addr <= {bank_r, cnt_r[IDX_W-1:0]};
                    otp_wdata <= regs_r[cnt_r[IDX_W-1:0]];
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r[IDX_W-1:0] == IDX_W'(REG_COUNT - 1)) begin
                        cnt_r <= '0;
                        st_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    cnt_r <= '0;
                    if (save_req) st_r <= ST_SAVE;
                    else if (restore_req) st_r <= ST_LOAD;
                    else if (reload_sel) begin
                        bank_r <= sel_s;
                        st_r <= ST_LOAD;
                    end
                end
                default: st_r <= ST_RUN;
            endcase
        end
    end

    assign my_addr = addr_select_bit ? SLAVE_ADDR_ALT : SLAVE_ADDR_DEFAULT;
    assign rd_data = reg_ptr_r < 8'(REG_COUNT) ? regs_r[reg_ptr_r[IDX_W-1:0]] : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            ph_r <= PH_IDLE;
            bitcnt_r <= '0;
            shift_r <= '0;
            rd_byte_r <= '0;
            reg_ptr_r <= '0;
            nbytes_r <= '0;
            wr_pend_r <= 1'b0;
            sda_low_r <= 1'b0;
            for (int i = 0; i < STAGE_DEPTH; i++) stage_r[i] <= '0;
        end else if (start_ev) begin
            ph_r <= PH_ADDR;
            bitcnt_r <= '0;
            sda_low_r <= 1'b0;
        end else if (stop_ev) begin
            ph_r <= PH_IDLE;
            wr_pend_r <= 1'b0;
            sda_low_r <= 1'b0;
        end else if (scl_rise) begin
            if (bitcnt_r < 4'h8) shift_r <= {shift_r[6:0], sda_s};
            if (bitcnt_r == 4'h8 && ph_r == PH_RD && sda_s) ph_r <= PH_SKIP;
            bitcnt_r <= bitcnt_r + 4'h1;
        end else if (scl_fall) begin
            if (bitcnt_r == 4'h8) begin
                sda_low_r <= 1'b0;
                case (ph_r)
                    PH_ADDR: if (shift_r[7:1] == my_addr && serial_en_r && !busy) begin
                        sda_low_r <= 1'b1;
                        ph_r <= shift_r[0] ? PH_RD : PH_REG;
                        if (shift_r[0]) wr_pend_r <= 1'b0;
                    end else begin
                        ph_r <= PH_SKIP;
                    end
                    PH_REG: begin
                        reg_ptr_r <= shift_r;
                        nbytes_r <= '0;
                        wr_pend_r <= 1'b1;
                        sda_low_r <= 1'b1;
                        ph_r <= PH_WR;
                    end
                    // Bytes past the staging depth are refused with no acknowledge
                    PH_WR: if (nbytes_r < 4'(STAGE_DEPTH)) begin
                        stage_r[nbytes_r[2:0]] <= shift_r;
                        nbytes_r <= nbytes_r + 4'h1;
                        sda_low_r <= 1'b1;
                    end
                    PH_RD: reg_ptr_r <= reg_ptr_r + 8'h1;
                    default: ;
                endcase
            end else if (bitcnt_r == 4'h9) begin
                bitcnt_r <= '0;
                rd_byte_r <= rd_data;
                sda_low_r <= (ph_r == PH_RD) & ~rd_data[7];
            end else if (ph_r == PH_RD) begin
                sda_low_r <= ~rd_byte_r[3'(4'h7 - bitcnt_r)];
            end
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe = sda_low_r;

    assign gsd = pin_function_bit & sdoe_s;
    for (genvar n = 0; n < OUTS; n++) begin : g_out
        assign output_state_bit[n] = regs_r[IDX_W'(REG_OUT_BASE + n)][BIT_OUT_STATE];
        assign output_enable_bit[n] = regs_r[IDX_W'(REG_OUT_BASE + n)][BIT_OUT_ENABLE];
        assign tri_v[n] = ~gsd & ~output_state_bit[n];
        // Enable mode disables when the pin differs from polarity; shutdown mode uses polarity
        assign act_v[n] = ~gsd & output_state_bit[n] & ~(output_enable_bit[n]
            & (pin_function_bit ? pin_polarity_bit : sdoe_s ^ pin_polarity_bit));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            clock_output_active <= '0;
            clock_output_tristate <= '1;
            pll_shutdown <= 1'b0;
        end else begin
            clock_output_active <= act_v;
            clock_output_tristate <= tri_v;
            pll_shutdown <= gsd;
        end
    end

    // Only the select is registered here; the clock mux itself must be glitch-free
    always_ff @(posedge clk) begin
        if (rst) use_external_reference <= 1'b0;
        else if (!switchover_mode_field[1])
            use_external_reference <= primary_source_bit ^ reference_select_pin_s;
    end
    assign serial_access_enabled = serial_en_r;
    assign config_active = bank_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ref_select_a: assert property (
        !switchover_mode_field[1] |=> use_external_reference == $past(primary_source_bit ^ reference_select_pin_s))
        else $error("reference select wrong");
    busy_nack_a: assert property (busy |-> !sda_oe) else $error("ack while busy");
    otp_save_a: assert property (
        st_r == ST_RUN && save_req |=> st_r == ST_SAVE ##(REG_COUNT) st_r == ST_RUN)
        else $error("save not run");
    otp_restore_a: assert property (
        st_r == ST_RUN && !save_req && restore_req |=> st_r == ST_LOAD) else $error("no restore");
    cmd_stop_a: assert property ($rose(st_r == ST_SAVE) |-> $past(stop_ev))
        else $error("save without stop");
    commit_stop_a: assert property (
        st_r == ST_RUN && !commit |=> $stable(regs_r[REG_PIN_CTRL])) else $error("write before stop");
    strap_hold_a: assert property (st_r != ST_STRAP |=> $stable(strap_r))
        else $error("strap changed");
    boot_load_a: assert property (
        st_r == ST_STRAP && start_cnt_r == STRAP_SAMPLE_CYC |=> st_r == ST_LOAD) else $error("no boot");
    pin_mode_a: assert property (pin_mode_r |-> !serial_en_r) else $error("serial in pin mode");
    serial_mode_a: assert property (
        st_r == ST_RUN && !strap_r |-> serial_en_r && !pin_mode_r) else $error("serial off");
    sel_follow_a: assert property (
        reload_sel |=> st_r == ST_LOAD && bank_r == $past(sel_s)) else $error("select ignored");
    settle_a: assert property (
        !settle_done |=> $stable(bank_r) || $past(st_r) != ST_RUN) else $error("reload too soon");
    address_ack_a: assert property (
        ph_r == PH_ADDR && scl_fall && bitcnt_r == 4'h8 && !busy && serial_en_r
        && shift_r[7:1] == (addr_select_bit ? 7'h68 : 7'h6a) |=> sda_oe) else $error("no addr ack");
    tristate_out_a: assert property (
        !gsd && !output_state_bit[0] |=> clock_output_tristate[0] && !clock_output_active[0])
        else $error("not tristated");
    global_sd_a: assert property (
        gsd |=> pll_shutdown && clock_output_active == '0 && clock_output_tristate == '0)
        else $error("shutdown wrong");
    enable_mode_a: assert property (
        !pin_function_bit && output_state_bit[0] && !output_enable_bit[0] |=> clock_output_active[0])
        else $error("output not active");
    sd_mode_a: assert property (
        gsd == 0 && pin_function_bit && output_state_bit[0] && output_enable_bit[0] && pin_polarity_bit
        |=> !clock_output_active[0] && !clock_output_tristate[0]) else $error("not forced");
    cover property (st_r == ST_SAVE ##1 st_r == ST_SAVE);
    cover property (st_r == ST_RUN && restore_req);
    cover property (reload_sel);
    cover property (gsd);
endmodule // ccg_ctrl
`default_nettype wire

//--- inc/ccg_pkg.sv
`default_nettype none
package ccg_pkg;
    localparam int REG_COUNT = 128;
    localparam int IDX_W = 7;
    localparam int BANK_W = 2;
    localparam int OUT_COUNT = 3;
    localparam int STAGE_DEPTH = 8;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [6:0] REG_FLAGS = 7'h00;
    localparam int BIT_SERIAL_DEFAULT = 7;
    localparam int BIT_ADDR_SELECT = 0;
    localparam logic [6:0] REG_REF = 7'h13;
    localparam int BIT_PRIMARY_SOURCE = 1;
    localparam int BIT_SWITCH_MODE_LO = 6;
    localparam logic [6:0] REG_PIN_CTRL = 7'h10;
    localparam int BIT_PIN_POLARITY = 1;
    localparam int BIT_PIN_FUNCTION = 0;
    localparam logic [6:0] REG_OTP_CTRL = 7'h72;
    localparam int BIT_OTP_SAVE = 3;
    localparam int BIT_OTP_RESTORE = 0;
    localparam logic [6:0] REG_OUT_BASE = 7'h68;
    localparam int BIT_OUT_STATE = 0;
    localparam int BIT_OUT_ENABLE = 1;
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h6a;
    localparam logic [6:0] SLAVE_ADDR_ALT = 7'h68;
    localparam logic [7:0] CMD_OTP_SAVE = 8'h08;
    localparam logic [7:0] CMD_OTP_RESTORE = 8'h01;
    localparam int CLK_MHZ = 200;
    localparam int SEL_START_MS = 10;
    localparam int SEL_SETTLE_MS = 1;
    localparam int SEL_START_CYC = SEL_START_MS * CLK_MHZ * 1000;
    localparam int SEL_SETTLE_CYC = SEL_SETTLE_MS * CLK_MHZ * 1000;
    localparam logic [31:0] STRAP_SAMPLE_CYC = 32'h00000002;
    localparam logic [7:0] LOAD_DRAIN_CYC = 8'h02;
    typedef enum logic [2:0] {ST_STRAP, ST_LOAD, ST_DRAIN, ST_PICK, ST_SAVE, ST_RUN} ccg_state_type;
    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_REG, PH_WR, PH_RD, PH_SKIP} ccg_phase_type;
endpackage
`default_nettype wire

//--- bench/ccg_otp_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccg_otp_model
    import ccg_pkg::*;
(
    input wire logic clk,
    input wire logic [BANK_W+IDX_W-1:0] otp_addr,
    input wire logic [7:0] otp_wdata,
    input wire logic otp_we,
    output logic [7:0] otp_rdata
);
    logic [7:0] mem [0:(1<<(BANK_W+IDX_W))-1];
    int write_count;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        // Bank 0 boots with the external input as primary, to see the power-up load
        mem[REG_REF] = 8'h02;
        write_count = 0;
    end
    // One cycle from address to data, as the array behaves
    always @(posedge clk) begin
        otp_rdata <= mem[otp_addr];
        if (otp_we) begin
            mem[otp_addr] <= otp_wdata;
            write_count <= write_count + 1;
        end
    end
endmodule // ccg_otp_model
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ccg_pkg::*;
    localparam int Q = 3;
    logic clk, rst, ref_pin, sd_pin, scl_m, sda_m, sda_oe, sda_out, busy, ser_en, use_ext, pll_sd;
    logic owe, ack, fn, pol, pin, force0, sd, strap, sel_lo, sel_hi;
    logic [1:0] cfg;
    logic [2:0] act, tri_s;
    logic [8:0] oaddr;
    logic [7:0] owdata, ordata;
    wire logic sda = sda_m & !sda_oe;
    int fail_count, checked;

    ccg_ctrl #(.START_CYC(64), .SETTLE_CYC(16)) i_ccg_ctrl (.clk(clk), .rst(rst),
        .serial_access_strap(strap), .config_select_low(sel_lo), .config_select_high(sel_hi),
        .reference_select_pin(ref_pin), .shutdown_enable_pin(sd_pin), .scl_in(scl_m),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .otp_addr(oaddr),
        .otp_wdata(owdata), .otp_we(owe), .otp_rdata(ordata), .busy(busy),
        .serial_access_enabled(ser_en), .config_active(cfg), .use_external_reference(use_ext),
        .pll_shutdown(pll_sd), .clock_output_active(act), .clock_output_tristate(tri_s));
    ccg_otp_model i_ccg_otp_model (.clk(clk), .otp_addr(oaddr), .otp_wdata(owdata),
        .otp_we(owe), .otp_rdata(ordata));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wq(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic i2c_bit(input logic b, output logic r);
        sda_m = b;
        wq(Q);
        scl_m = 1'b1;
        wq(Q);
        r = sda;
        wq(Q);
        scl_m = 1'b0;
        wq(Q);
    endtask
    task automatic i2c_byte(input logic [7:0] d, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) i2c_bit(d[i], r);
        i2c_bit(1'b1, r);
        a = !r;
    endtask
    task automatic i2c_start();
        sda_m = 1'b1;
        scl_m = 1'b1;
        wq(Q);
        sda_m = 1'b0;
        wq(Q);
        scl_m = 1'b0;
        wq(Q);
    endtask
    task automatic i2c_stop();
        sda_m = 1'b0;
        wq(Q);
        scl_m = 1'b1;
        wq(Q);
        sda_m = 1'b1;
        wq(Q + 4);
    endtask
    task automatic open_wr(input logic [6:0] r);
        i2c_start();
        i2c_byte({SLAVE_ADDR_DEFAULT, 1'b0}, ack);
        chk("addr_ack", ack, 1);
        i2c_byte({1'b0, r}, ack);
        chk("ptr_ack", ack, 1);
    endtask
    task automatic wr(input logic [6:0] r, input logic [7:0] d[$]);
        open_wr(r);
        foreach (d[i]) i2c_byte(d[i], ack);
        i2c_stop();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) wq(1);
        chk("busy_low", busy, 0);
    endtask
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Generous bound: the sequence needs well under a third of this
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_sim();
    end

    initial begin
        fail_count = 0;
        checked = 0;
        rst = 1'b1;
        ref_pin = 1'b0;
        sd_pin = 1'b0;
        strap = 1'b0;
        sel_lo = 1'b0;
        sel_hi = 1'b0;
        scl_m = 1'b1;
        sda_m = 1'b1;
        wq(8);
        rst = 1'b0;
        wait_idle();
        wq(8);
        chk("serial_on", ser_en, 1);
        chk("config", cfg, 0);
        chk("sda_out", sda_out, 0);
        chk("ref_boot", use_ext, 1);
        ref_pin = 1'b1;
        wq(10);
        chk("ref_swap", use_ext, 0);
        open_wr(REG_REF);
        i2c_byte(8'h00, ack);
        wq(10);
        chk("ref_staged", use_ext, 0);
        i2c_stop();
        wq(6);
        chk("ref_commit", use_ext, 1);
        i2c_start();
        i2c_byte({SLAVE_ADDR_ALT, 1'b0}, ack);
        chk("alt_nack", ack, 0);
        i2c_stop();
        wr(REG_OUT_BASE, '{8'h03, 8'h01, 8'h02});
        for (int k = 0; k < 8; k++) begin
            {pin, pol, fn} = k[2:0];
            wr(REG_PIN_CTRL, '{{6'h00, pol, fn}});
            sd_pin = pin;
            wq(10);
            sd = fn & pin;
            force0 = fn ? (!pin & pol) : (pin ^ pol);
            chk("shutdown", pll_sd, sd);
            chk("active", act, sd ? 3'b000 : {2'b01, !force0});
            chk("tristate", tri_s, sd ? 3'b000 : 3'b100);
        end
        sd_pin = 1'b0;
        i2c_start();
        i2c_byte({SLAVE_ADDR_DEFAULT, 1'b0}, ack);
        i2c_byte(CMD_OTP_SAVE, ack);
        i2c_stop();
        chk("save_busy", busy, 1);
        i2c_start();
        i2c_byte({SLAVE_ADDR_DEFAULT, 1'b0}, ack);
        chk("busy_nack", ack, 0);
        i2c_stop();
        wait_idle();
        chk("otp_writes", i_ccg_otp_model.write_count[15:0], 16'd128);
        chk("otp_pin_ctrl", i_ccg_otp_model.mem[REG_PIN_CTRL], 8'h03);
        wr(REG_REF, '{8'h00});
        wr(REG_PIN_CTRL, '{8'h00});
        i2c_start();
        i2c_byte({SLAVE_ADDR_DEFAULT, 1'b0}, ack);
        i2c_byte(CMD_OTP_RESTORE, ack);
        i2c_stop();
        wait_idle();
        sd_pin = 1'b1;
        wq(10);
        chk("restored", pll_sd, 1);
        sd_pin = 1'b0;
        wr(REG_FLAGS, '{8'h01});
        i2c_start();
        i2c_byte({SLAVE_ADDR_ALT, 1'b0}, ack);
        chk("alt_ack", ack, 1);
        i2c_stop();
        // Second power-on with the strap high: select pins now pick the bank
        strap = 1'b1;
        sel_hi = 1'b1;
        rst = 1'b1;
        wq(8);
        rst = 1'b0;
        wait_idle();
        chk("pin_serial", ser_en, 0);
        chk("pin_config", cfg, 2);
        i2c_start();
        i2c_byte({SLAVE_ADDR_DEFAULT, 1'b0}, ack);
        chk("pin_nack", ack, 0);
        i2c_stop();
        sel_lo = 1'b1;
        wq(10);
        chk("sel_follow", cfg, 3);
        chk("sel_busy", busy, 1);
        wait_idle();
        sel_hi = 1'b0;
        wq(10);
        chk("sel_follow2", cfg, 1);
        wait_idle();
        end_sim();
    end
endmodule // testbench
`default_nettype wire
